/* File: hw/lsm_i2c_port.sv */
// I2C target command port of the eight-channel LED bypass switch controller
`timescale 1ns/1ps
module lsm_i2c_port import lsm_pkg::*; #(
    parameter logic [7:0] ACM_INIT = ACM_RESET
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // I2C bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Address select pins
    input wire logic [3:0] addr_sel,
    // Fault sense and chip state
    input wire logic [7:0] open_fault_in,
    input wire logic [7:0] short_fault_in,
    input wire logic overheat_in,
    input wire logic shutdown_in,
    output logic alert_n,
    // Command register outputs
    output logic [7:0] all_channel_control_reg,
    output logic [7:0] switch_on,
    output logic [7:0][1:0] channel_switch_mode,
    output logic [7:0][1:0] open_threshold_code,
    output logic [7:0][1:0] short_threshold_code,
    output logic [7:0][7:0] dimming_value,
    output logic [7:0] dim_enable,
    output logic [7:0] fade_enable,
    output logic [7:0] open_led_fault_status,
    output logic [7:0] shorted_led_fault_status
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
    logic [7:0] opn_m_q, opn_s_q, sht_m_q, sht_s_q;
    logic oh_m_q, oh_s_q, sd_m_q, sd_s_q;
    logic [3:0] adr_m_q, adr_s_q;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
            {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
            {opn_m_q, opn_s_q, sht_m_q, sht_s_q} <= 32'h0000_0000;
            {oh_m_q, oh_s_q, sd_m_q, sd_s_q} <= 4'h0;
            {adr_m_q, adr_s_q} <= 8'h00;
        end else begin
            {scl_m_q, scl_s_q, scl_p_q} <= {scl_in, scl_m_q, scl_s_q};
            {sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
            {opn_m_q, opn_s_q} <= {open_fault_in, opn_m_q};
            {sht_m_q, sht_s_q} <= {short_fault_in, sht_m_q};
            {oh_m_q, oh_s_q} <= {overheat_in, oh_m_q};
            {sd_m_q, sd_s_q} <= {shutdown_in, sd_m_q};
            // Address pins are board straps but still cross in asynchronously
            {adr_m_q, adr_s_q} <= {addr_sel, adr_m_q};
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise = scl_s_q & ~scl_p_q;
    assign scl_fall = ~scl_s_q & scl_p_q;
    // START and repeated START look the same
    assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // ----------------------------------------
    // State
    // ----------------------------------------
    lsm_state_type state_q, state_d;
    logic [3:0] bit_q, bit_d;
    logic [1:0] idx_q, idx_d, rd_idx;
    logic [7:0] sh_q, sh_d, tx_q, tx_d, rd_byte;
    logic rw_q, rw_d, sc_q, sc_d, nack_q, nack_d, oe_q, oe_d;
    logic long_q, long_d;
    logic [2:0] chan_q, chan_d;
    logic [7:0] hold_ac_q, hold_ac_d;
    logic ac_pend_q, ac_pend_d;
    logic [7:0][1:0] hold_mode_q, hold_mode_d;
    logic [7:0][7:0] hold_dim_q, hold_dim_d;
    logic [7:0] mode_pend_q, mode_pend_d, dim_pend_q, dim_pend_d;
    logic [7:0][1:0] oth_q, oth_d, sth_q, sth_d, mode_q, mode_d;
    logic [7:0][7:0] dim_q, dim_d;
    logic [7:0] ac_q, ac_d, sw_q, sw_d;
    logic [6:0] cnt_q, cnt_d;
    logic busy_q, busy_d;
    logic [7:0] opn_q, opn_d, sht_q, sht_d, den_q, den_d, fen_q, fen_d;
    logic alert_n_q, alert_n_d;
    logic [1:0] cur_mode;
    logic [7:0] cur_dim;

    // ----------------------------------------
    // Read data selection
    // ----------------------------------------
    assign rd_idx = (state_q == ST_ACKA) ? RD_CTRL : 2'(idx_q + 2'h1);
    assign cur_mode = mode_pend_q[chan_q] ? hold_mode_q[chan_q] : mode_q[chan_q];
    assign cur_dim = dim_pend_q[chan_q] ? hold_dim_q[chan_q] : dim_q[chan_q];

    always_comb begin
        rd_byte = 8'hFF;
        if (sc_q) begin
            // channel from the last single write
            if (rd_idx == RD_CTRL) begin
                rd_byte = {opn_q[chan_q], sht_q[chan_q], oth_q[chan_q], sth_q[chan_q],
                    cur_mode};
            end else if (rd_idx == RD_OPEN) begin
                rd_byte = cur_dim;
            end
        end else begin
            unique case (rd_idx)
                RD_CTRL: rd_byte = ac_pend_q ? hold_ac_q : ac_q;
                RD_OPEN: rd_byte = opn_q;
                RD_SHORT: rd_byte = sht_q;
                default: rd_byte = 8'hFF;
            endcase
        end
    end

    // ----------------------------------------
    // Protocol, latches and commit
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        bit_d = bit_q;
        idx_d = idx_q;
        sh_d = sh_q;
        tx_d = tx_q;
        rw_d = rw_q;
        sc_d = sc_q;
        nack_d = nack_q;
        oe_d = oe_q;
        long_d = long_q;
        chan_d = chan_q;
        hold_ac_d = hold_ac_q;
        ac_pend_d = ac_pend_q;
        hold_mode_d = hold_mode_q;
        hold_dim_d = hold_dim_q;
        mode_pend_d = mode_pend_q;
        dim_pend_d = dim_pend_q;
        oth_d = oth_q;
        sth_d = sth_q;
        mode_d = mode_q;
        dim_d = dim_q;
        ac_d = ac_q;
        sw_d = sw_q;
        cnt_d = cnt_q;
        busy_d = busy_q;
        if (busy_q) begin
            cnt_d = 7'(cnt_q + 7'h01);
            if (cnt_q == 7'(SW_ON_CYC)) begin
                sw_d = sw_q | ~ac_q;
            end
            if (cnt_q == 7'(SW_OFF_CYC)) begin
                sw_d = ~ac_q;
                busy_d = 1'b0;
            end
        end
        unique case (state_q)
            ST_IDLE: begin
                oe_d = 1'b0;
            end
            ST_ADDR: begin
                // eight bits, then the acknowledge slot
                if (scl_rise) begin
                    sh_d = {sh_q[6:0], sda_s_q};
                    bit_d = 4'(bit_q + 4'h1);
                end else if (scl_fall && bit_q == BYTE_BITS) begin
                    rw_d = sh_q[0];
                    if (sh_q[7:1] == {ACM_PREFIX, adr_s_q}) begin
                        sc_d = 1'b0;
                        oe_d = 1'b1;
                        state_d = ST_ACKA;
                    end else if (sh_q[7:1] == {SCM_PREFIX, adr_s_q}) begin
                        sc_d = 1'b1;
                        oe_d = 1'b1;
                        state_d = ST_ACKA;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_ACKA: begin
                if (scl_fall) begin
                    bit_d = 4'h0;
                    idx_d = RD_CTRL;
                    if (rw_q) begin
                        tx_d = rd_byte;
                        oe_d = ~rd_byte[7];
                        state_d = ST_RD;
                    end else begin
                        oe_d = 1'b0;
                        state_d = ST_WR;
                    end
                end
            end
            ST_WR: begin
                if (scl_rise) begin
                    sh_d = {sh_q[6:0], sda_s_q};
                    bit_d = 4'(bit_q + 4'h1);
                end else if (scl_fall && bit_q == BYTE_BITS) begin
                    // acknowledge every data byte, latch only the first one and a long single write's dimming byte
                    oe_d = 1'b1;
                    state_d = ST_ACKW;
                    if (!sc_q && idx_q == RD_CTRL) begin
                        // one data byte for all channels
                        hold_ac_d = sh_q;
                        ac_pend_d = 1'b1;
                    end else if (sc_q && idx_q == RD_CTRL) begin
                        long_d = sh_q[FMT_BIT];
                        chan_d = sh_q[CH_LO +: 3];
                        hold_mode_d[sh_q[CH_LO +: 3]] = sh_q[MODE_LO +: 2];
                        mode_pend_d[sh_q[CH_LO +: 3]] = 1'b1;
                        // thresholds take effect at the ack
                        if (sh_q[FMT_BIT]) begin
                            sth_d[sh_q[CH_LO +: 3]] = sh_q[THR_LO +: 2];
                        end else begin
                            oth_d[sh_q[CH_LO +: 3]] = sh_q[THR_LO +: 2];
                        end
                    end else if (sc_q && long_q && idx_q == RD_OPEN) begin
                        hold_dim_d[chan_q] = (sh_q == DIM_ZERO) ? DIM_MIN : sh_q;
                        dim_pend_d[chan_q] = 1'b1;
                    end
                end
            end
            ST_ACKW: begin
                if (scl_fall) begin
                    oe_d = 1'b0;
                    bit_d = 4'h0;
                    idx_d = (idx_q == RD_SHORT) ? idx_q : 2'(idx_q + 2'h1);
                    state_d = ST_WR;
                end
            end
            ST_RD: begin
                if (scl_rise) begin
                    bit_d = 4'(bit_q + 4'h1);
                end else if (scl_fall) begin
                    if (bit_q == BYTE_BITS) begin
                        oe_d = 1'b0;
                        state_d = ST_HACK;
                    end else begin
                        tx_d = {tx_q[6:0], 1'b0};
                        oe_d = ~tx_q[6];
                    end
                end
            end
            ST_HACK: begin
                if (scl_rise) begin
                    nack_d = sda_s_q;
                end else if (scl_fall) begin
                    bit_d = 4'h0;
                    // a host nack ends the read
                    if (nack_q) begin
                        state_d = ST_IDLE;
                    end else begin
                        idx_d = rd_idx;
                        tx_d = rd_byte;
                        oe_d = ~rd_byte[7];
                        state_d = ST_RD;
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // every command opens with an address byte
        if (start_det) begin
            state_d = ST_ADDR;
            bit_d = 4'h0;
            oe_d = 1'b0;
            nack_d = 1'b0;
        end
        if (stop_det) begin
            state_d = ST_IDLE;
            oe_d = 1'b0;
            if (ac_pend_q) begin
                ac_d = hold_ac_q;
                cnt_d = 7'h01;
                busy_d = 1'b1;
            end
            ac_pend_d = 1'b0;
            for (int i = 0; i < 8; i++) begin
                if (mode_pend_q[i]) begin
                    mode_d[i] = hold_mode_q[i];
                end
                if (dim_pend_q[i]) begin
                    dim_d[i] = hold_dim_q[i];
                end
            end
            mode_pend_d = 8'h00;
            dim_pend_d = 8'h00;
        end
    end

    // ----------------------------------------
    // Fault status and mode decode
    // ----------------------------------------
    always_comb begin
        opn_d = opn_s_q;
        sht_d = sht_s_q;
        alert_n_d = ~(|opn_s_q | |sht_s_q);
        if (sd_s_q) begin
            opn_d = FAULT_ALL;
            sht_d = FAULT_ALL;
            alert_n_d = 1'b1;
        end else if (oh_s_q) begin
            opn_d = FAULT_ALL;
            sht_d = FAULT_ALL;
            alert_n_d = 1'b0;
        end
        for (int i = 0; i < 8; i++) begin
            den_d[i] = (mode_q[i] == MODE_DIM) || (mode_q[i] == MODE_FADE);
            fen_d[i] = (mode_q[i] == MODE_FADE);
        end
    end

    // without STOP pending data just waits
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            {bit_q, idx_q, sh_q, tx_q} <= 22'h00_0000;
            {rw_q, sc_q, nack_q, oe_q, long_q} <= 5'h00;
            chan_q <= 3'h0;
            hold_ac_q <= ACM_INIT;
            ac_pend_q <= 1'b0;
            hold_mode_q <= {8{MODE_RESET}};
            hold_dim_q <= {8{DIM_RESET}};
            {mode_pend_q, dim_pend_q} <= 16'h0000;
            oth_q <= {8{OTH_RESET}};
            sth_q <= {8{STH_RESET}};
            mode_q <= {8{MODE_RESET}};
            dim_q <= {8{DIM_RESET}};
            ac_q <= ACM_INIT;
            sw_q <= ~ACM_INIT;
            cnt_q <= 7'h00;
            busy_q <= 1'b0;
            opn_q <= FAULT_NONE;
            sht_q <= FAULT_NONE;
            {den_q, fen_q} <= 16'h0000;
            alert_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            {bit_q, idx_q, sh_q, tx_q} <= {bit_d, idx_d, sh_d, tx_d};
            {rw_q, sc_q, nack_q, oe_q, long_q} <= {rw_d, sc_d, nack_d, oe_d, long_d};
            chan_q <= chan_d;
            hold_ac_q <= hold_ac_d;
            ac_pend_q <= ac_pend_d;
            hold_mode_q <= hold_mode_d;
            hold_dim_q <= hold_dim_d;
            {mode_pend_q, dim_pend_q} <= {mode_pend_d, dim_pend_d};
            oth_q <= oth_d;
            sth_q <= sth_d;
            mode_q <= mode_d;
            dim_q <= dim_d;
            ac_q <= ac_d;
            sw_q <= sw_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            opn_q <= opn_d;
            sht_q <= sht_d;
            {den_q, fen_q} <= {den_d, fen_d};
            alert_n_q <= alert_n_d;
        end
    end

    // Open drain: the data level is always low, the enable does the work
    assign sda_out = 1'b0;
    assign sda_oe = oe_q;
    assign alert_n = alert_n_q;
    assign all_channel_control_reg = ac_q;
    assign switch_on = sw_q;
    assign channel_switch_mode = mode_q;
    assign open_threshold_code = oth_q;
    assign short_threshold_code = sth_q;
    assign dimming_value = dim_q;
    assign dim_enable = den_q;
    assign fade_enable = fen_q;
    assign open_led_fault_status = opn_q;
    assign shorted_led_fault_status = sht_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    localparam int SW_MAX = SW_OFF_CYC + 2;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_commit_ac;
        stop_det && ac_pend_q;
    endsequence
    a_dim_nonzero: assert property (dim_q[chan_q] != DIM_ZERO)
        else $error("dimming value zero");
    a_overheat_all: assert property (oh_s_q && !sd_s_q |=> opn_q == FAULT_ALL && !alert_n_q)
        else $error("overheat not reported");
    a_shutdown_all: assert property (sd_s_q |=> sht_q == FAULT_ALL && alert_n_q)
        else $error("shutdown not reported");
    a_addr_ack: assert property (state_q == ST_ACKA |-> oe_q)
        else $error("address not acknowledged");
    a_commit_stop: assert property ($changed(ac_q) |-> $past(stop_det))
        else $error("control changed without stop");
    a_latch_held: assert property (ac_pend_q && !stop_det |=> ac_pend_q)
        else $error("latched data lost");
    a_thr_on_ack: assert property ($changed(oth_q) |-> state_q == ST_ACKW)
        else $error("threshold changed off ack");
    a_switch_time: assert property (s_commit_ac |-> ##[1:SW_MAX] sw_q == ~ac_q)
        else $error("switch late");
    a_nack_end: assert property (state_q == ST_HACK && nack_q && scl_fall && !start_det
        && !stop_det |=> state_q == ST_IDLE && !oe_q)
        else $error("read not ended on nack");
endmodule : lsm_i2c_port

/* File: hw/lsm_pkg.sv */
// Constants and types for the LED switch matrix command port
package lsm_pkg;
    // ----------------------------------------
    // Addressing and field layout
    // ----------------------------------------
    localparam logic [2:0] ACM_PREFIX = 3'h2;
    localparam logic [2:0] SCM_PREFIX = 3'h5;
    localparam int FMT_BIT = 7;
    localparam int CH_LO = 4;
    localparam int THR_LO = 2;
    localparam int MODE_LO = 0;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] RD_CTRL = 2'h0;
    localparam logic [1:0] RD_OPEN = 2'h1;
    localparam logic [1:0] RD_SHORT = 2'h2;
    // ----------------------------------------
    // Reset values and codes
    // ----------------------------------------
    localparam logic [7:0] ACM_RESET = 8'hFF;
    localparam logic [1:0] OTH_RESET = 2'h3;
    localparam logic [1:0] STH_RESET = 2'h0;
    localparam logic [1:0] MODE_RESET = 2'h1;
    localparam logic [7:0] DIM_RESET = 8'h01;
    localparam logic [7:0] DIM_ZERO = 8'h00;
    localparam logic [7:0] DIM_MIN = 8'h01;
    localparam logic [7:0] FAULT_NONE = 8'h00;
    localparam logic [7:0] FAULT_ALL = 8'hFF;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_ON = 2'h1;
    localparam logic [1:0] MODE_DIM = 2'h2;
    localparam logic [1:0] MODE_FADE = 2'h3;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_NS = 20;
    localparam int SW_ON_NS = 300;
    localparam int SW_OFF_NS = 1000;
    localparam int SW_ON_CYC = (SW_ON_NS / CLK_NS < 1) ? 1 : SW_ON_NS / CLK_NS;
    localparam int SW_OFF_CYC = (SW_OFF_NS / CLK_NS < 1) ? 1 : SW_OFF_NS / CLK_NS;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_ACKA = 7'h04,
        ST_WR = 7'h08,
        ST_ACKW = 7'h10,
        ST_RD = 7'h20,
        ST_HACK = 7'h40
    } lsm_state_type;
endpackage : lsm_pkg

/* File: tb/lsm_host.sv */
// Bus controller model that drives the command port from the host side
`timescale 1ns/1ps
module lsm_host (
    // Clock
    input wire logic mclk,
    // Bus
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    logic scl_q = 1'b1;
    logic hold_low_q = 1'b0;
    // Open drain with pull-up: a released line reads high
    assign scl = scl_q;
    assign sda = !(hold_low_q || sda_oe);

    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
    endtask : wait_n

    // one bit: data set in the low phase, sampled at the end of high
    task automatic put_bit(input logic b, output logic r);
        wait_n(2);
        hold_low_q <= !b;
        wait_n(2);
        scl_q <= 1'b1;
        wait_n(4);
        r = sda;
        scl_q <= 1'b0;
    endtask : put_bit

    // one sequence serves both START and repeated START
    task automatic start();
        wait_n(2);
        hold_low_q <= 1'b0;
        wait_n(4);
        scl_q <= 1'b1;
        wait_n(4);
        hold_low_q <= 1'b1;
        wait_n(4);
        scl_q <= 1'b0;
    endtask : start

    task automatic stop();
        wait_n(2);
        hold_low_q <= 1'b1;
        wait_n(4);
        scl_q <= 1'b1;
        wait_n(4);
        hold_low_q <= 1'b0;
        wait_n(4);
    endtask : stop

    // the controller sends one byte, MSB first, then releases the line for the ack
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) put_bit(b[i], r);
        put_bit(1'b1, r);
        ack = !r;
    endtask : wr_byte

    // controller acknowledges every read byte but the last
    task automatic rd_byte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, r);
            b[i] = r;
        end
        put_bit(last, r);
    endtask : rd_byte
endmodule : lsm_host

/* File: tb/lsm_i2c_port_tb.sv */
// Self-checking bench for the LED switch matrix command port
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("ERROR %0t: got %h expected %h", $time, (a), (e)); end end
module lsm_i2c_port_tb import lsm_pkg::*; ;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr_sel = 4'h0;
    logic [7:0] open_f = 8'h00;
    logic [7:0] short_f = 8'h00;
    logic overheat = 1'b0;
    logic shutdown = 1'b0;
    logic scl, sda, sda_out, sda_oe, alert_n;
    logic [7:0] all_channel_control_reg, switch_on, dim_enable, fade_enable;
    logic [7:0] open_led_fault_status, shorted_led_fault_status;
    logic [7:0][1:0] channel_switch_mode, open_threshold_code, short_threshold_code;
    logic [7:0][7:0] dimming_value;
    int mismatches = 0;
    int n_checks = 0;
    // Reference model of the committed registers
    logic [7:0] m_ctrl = ACM_RESET;
    logic [1:0] m_oth [8];
    logic [1:0] m_sth [8];
    logic [1:0] m_mode [8];
    logic [7:0] m_dim [8];
    logic [7:0] m_open = 8'h00;
    logic [7:0] m_short = 8'h00;

    always #10 mclk = ~mclk;

    lsm_i2c_port DUT (.mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .open_fault_in(open_f),
        .short_fault_in(short_f), .overheat_in(overheat), .shutdown_in(shutdown),
        .alert_n(alert_n), .all_channel_control_reg(all_channel_control_reg),
        .switch_on(switch_on), .channel_switch_mode(channel_switch_mode),
        .open_threshold_code(open_threshold_code), .short_threshold_code(short_threshold_code),
        .dimming_value(dimming_value), .dim_enable(dim_enable), .fade_enable(fade_enable),
        .open_led_fault_status(open_led_fault_status),
        .shorted_led_fault_status(shorted_led_fault_status));

    lsm_host host (.mclk(mclk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic chk_all();
        `CHK(all_channel_control_reg, m_ctrl)
        for (int c = 0; c < 8; c++) begin
            `CHK(channel_switch_mode[c], m_mode[c])
            `CHK(open_threshold_code[c], m_oth[c])
            `CHK(short_threshold_code[c], m_sth[c])
            `CHK(dimming_value[c], m_dim[c])
            `CHK(dim_enable[c], m_mode[c][1])
            `CHK(fade_enable[c], m_mode[c] == MODE_FADE)
        end
    endtask : chk_all

    task automatic wr(input logic [7:0] b, input logic exp_ack);
        logic ack;
        host.wr_byte(b, ack);
        `CHK(ack, exp_ack)
    endtask : wr

    task automatic rd(input logic last, input logic [7:0] e);
        logic [7:0] b;
        host.rd_byte(last, b);
        `CHK(b, e)
    endtask : rd

    task automatic sread(input logic [2:0] ch);
        host.start();
        wr({SCM_PREFIX, addr_sel, 1'b1}, 1'b1);
        rd(1'b0, {m_open[ch], m_short[ch], m_oth[ch], m_sth[ch], m_mode[ch]});
        rd(1'b1, m_dim[ch]);
        host.stop();
    endtask : sread

    task automatic acw(input logic [7:0] d);
        host.start();
        wr({ACM_PREFIX, addr_sel, 1'b0}, 1'b1);
        wr(d, 1'b1);
        host.stop();
        m_ctrl = d;
    endtask : acw

    initial begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        conclude();
    end

    initial begin
        logic [7:0] d, f;
        logic [2:0] ch;
        logic [1:0] th;
        void'($urandom(32'h7662c59b));
        addr_sel <= 4'($urandom);
        for (int c = 0; c < 8; c++) begin
            m_oth[c] = OTH_RESET;
            m_sth[c] = STH_RESET;
            m_mode[c] = MODE_RESET;
            m_dim[c] = DIM_RESET;
        end
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        chk_all();
        `CHK(open_led_fault_status, FAULT_NONE)
        `CHK(shorted_led_fault_status, FAULT_NONE)
        `CHK(alert_n, 1'b1)
        `CHK(sda_oe, 1'b0)
        `CHK(sda_out, 1'b0)
        sread(3'h0);
        // Pending byte survives a refused address and reads back before STOP
        d = 8'($urandom);
        host.start();
        wr({ACM_PREFIX, addr_sel, 1'b0}, 1'b1);
        wr(d, 1'b1);
        host.start();
        wr({ACM_PREFIX, ~addr_sel, 1'b0}, 1'b0);
        host.start();
        wr({ACM_PREFIX, addr_sel, 1'b1}, 1'b1);
        rd(1'b0, d);
        rd(1'b0, FAULT_NONE);
        rd(1'b1, FAULT_NONE);
        chk_all();
        host.stop();
        m_ctrl = d;
        repeat (17) @(posedge mclk);
        chk_all();
        `CHK(switch_on, ~d)
        // Opposite pattern: turn-on is quick, turn-off is slow
        acw(~d);
        repeat (17) @(posedge mclk);
        `CHK(switch_on, 8'hFF)
        repeat (40) @(posedge mclk);
        `CHK(switch_on, d)
        // slow driver: one channel per write
        acw(~d ^ 8'h01);
        repeat (60) @(posedge mclk);
        `CHK(switch_on, d ^ 8'h01)
        chk_all();
        for (int k = 0; k < 4; k++) begin
            ch = 3'($urandom);
            th = 2'($urandom);
            host.start();
            wr({SCM_PREFIX, addr_sel, 1'b0}, 1'b1);
            wr({1'b0, ch, th, 2'(k)}, 1'b1);
            m_oth[ch] = th;
            repeat (8) @(posedge mclk);
            chk_all();
            host.stop();
            m_mode[ch] = 2'(k);
            repeat (6) @(posedge mclk);
            chk_all();
            // Zero dimming on even passes
            d = k[0] ? 8'($urandom) : DIM_ZERO;
            host.start();
            wr({SCM_PREFIX, addr_sel, 1'b0}, 1'b1);
            wr({1'b1, ch, ~th, ~2'(k)}, 1'b1);
            m_sth[ch] = ~th;
            wr(d, 1'b1);
            host.stop();
            m_mode[ch] = ~2'(k);
            m_dim[ch] = (d == DIM_ZERO) ? DIM_MIN : d;
            repeat (6) @(posedge mclk);
            chk_all();
            sread(ch);
        end
        // Fault inputs, then overheat, then shutdown on top of it
        f = 8'($urandom);
        open_f <= f | 8'h01;
        short_f <= ~f;
        repeat (8) @(posedge mclk);
        `CHK(open_led_fault_status, f | 8'h01)
        `CHK(shorted_led_fault_status, ~f)
        m_open = f | 8'h01;
        m_short = ~f;
        // fault bytes read back over the bus
        host.start();
        wr({ACM_PREFIX, addr_sel, 1'b1}, 1'b1);
        rd(1'b0, m_ctrl);
        rd(1'b0, m_open);
        rd(1'b1, m_short);
        host.stop();
        sread(ch);
        open_f <= 8'h00;
        short_f <= 8'h00;
        overheat <= 1'b1;
        repeat (8) @(posedge mclk);
        `CHK({open_led_fault_status, shorted_led_fault_status, alert_n}, 17'h1FFFE)
        shutdown <= 1'b1;
        repeat (8) @(posedge mclk);
        `CHK({open_led_fault_status, shorted_led_fault_status, alert_n}, 17'h1FFFF)
        conclude();
    end
endmodule : lsm_i2c_port_tb
